// ### rcs_top.sv
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rcs_top #(
  parameter int POWERUP_TIMER_CYCLES = rcs_pkg::POWERUP_TIMER_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [1:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              ext_reset_pin_b,
  input  wire logic              bor_trip,
  input  wire logic              brownout_ready,
  input  wire logic              stack_overflow_evt,
  input  wire logic              stack_underflow_evt,
  input  wire logic              reset_instr_evt,
  input  wire logic              sleep_enter_evt,
  input  wire logic              wdt_timeout_evt,
  input  wire logic              int_wake_evt,
  input  wire logic              gie,
  input  wire logic              stack_fault_reset_en,
  input  wire logic              powerup_delay_disable_n,
  input  wire rcs_pkg::rcs_osc_t osc_mode,
  output logic                   core_reset,
  output logic                   pc_load_zero,
  output logic                   wake_resume,
  output logic                   wake_vector,
  output logic                   sw_brownout_enable,
  output logic      [4:0]        wdt_period_sel,
  output logic                   wdt_sw_enable
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic       pin_prev;
  logic       bor_prev;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync1    <= rcs_pkg::SYNC_RST;
      sync2    <= rcs_pkg::SYNC_RST;
      pin_prev <= 1'b1;
      bor_prev <= 1'b0;
    end else begin
      sync1    <= {brownout_ready, bor_trip, ext_reset_pin_b};
      sync2    <= sync1;
      pin_prev <= sync2[0];
      bor_prev <= sync2[1];
    end
  end

  wire pin_low   = !sync2[0];
  wire pin_fall  = pin_prev && pin_low;
  wire bor_level = sync2[1];
  wire bor_rise  = bor_level && !bor_prev;
  wire bor_rdy   = sync2[2];

  // ****************************************
  // Event qualification and priority
  // ****************************************
  rcs_pkg::rcs_state_t state;
  rcs_pkg::rcs_state_t next_state;
  rcs_timer_if         tif ();

  wire in_boot  = state == rcs_pkg::ST_BOOT;
  wire in_wait  = state == rcs_pkg::ST_WAIT;
  wire in_hold  = state == rcs_pkg::ST_HOLD;
  wire in_run   = state == rcs_pkg::ST_RUN;
  wire in_sleep = state == rcs_pkg::ST_SLEEP;

  wire ev_bor   = bor_rise;
  wire ev_pin   = pin_fall && !bor_level && (in_run || in_sleep);
  wire pin_slp  = ev_pin && in_sleep;
  wire free_run = in_run && !bor_level && !ev_pin;
  wire free_slp = in_sleep && !bor_level && !ev_pin;
  wire ev_wdt   = wdt_timeout_evt && free_run;
  wire ev_wwake = wdt_timeout_evt && free_slp;
  wire ev_iwake = int_wake_evt && free_slp && !wdt_timeout_evt;
  wire ev_wake  = ev_wwake || ev_iwake;
  wire ev_ovf   = stack_overflow_evt && free_run && !ev_wdt;
  wire ev_unf   = stack_underflow_evt && free_run && !ev_wdt;
  wire stk_rst  = (ev_ovf || ev_unf) && stack_fault_reset_en;
  wire ev_ri    = reset_instr_evt && free_run && !ev_wdt && !stk_rst;
  wire ev_sleep = sleep_enter_evt && free_run && !ev_wdt &&
                  !stk_rst && !ev_ri;
  wire soft_rst = ev_pin || ev_wdt || stk_rst || ev_ri;

  // ****************************************
  // Reset and wake sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    case (state)
      rcs_pkg::ST_BOOT: begin
        if (!bor_level)
          next_state = rcs_pkg::ST_WAIT;
      end
      rcs_pkg::ST_WAIT: begin
        if (bor_level)
          next_state = rcs_pkg::ST_BOOT;
        else if (tif.done && pin_low)
          next_state = rcs_pkg::ST_HOLD;
        else if (tif.done)
          next_state = rcs_pkg::ST_RUN;
      end
      rcs_pkg::ST_HOLD: begin
        if (bor_level)
          next_state = rcs_pkg::ST_BOOT;
        else if (!pin_low)
          next_state = rcs_pkg::ST_RUN;
      end
      rcs_pkg::ST_RUN: begin
        if (bor_level)
          next_state = rcs_pkg::ST_BOOT;
        else if (soft_rst)
          next_state = rcs_pkg::ST_HOLD;
        else if (ev_sleep)
          next_state = rcs_pkg::ST_SLEEP;
      end
      rcs_pkg::ST_SLEEP: begin
        if (bor_level)
          next_state = rcs_pkg::ST_BOOT;
        else if (ev_pin)
          next_state = rcs_pkg::ST_HOLD;
        else if (ev_wake)
          next_state = rcs_pkg::ST_WAIT;
      end
      default: next_state = rcs_pkg::ST_BOOT;
    endcase
  end

  logic wake_pend;
  logic wake_int;

  wire wait_done = in_wait && tif.done && !bor_level && !pin_low;
  wire hold_exit = in_hold && !bor_level && !pin_low;
  wire next_zero = (wait_done && !wake_pend) || hold_exit;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state        <= rcs_pkg::ST_BOOT;
      wake_pend    <= 1'b0;
      wake_int     <= 1'b0;
      pc_load_zero <= 1'b0;
      wake_resume  <= 1'b0;
      wake_vector  <= 1'b0;
    end else begin
      state        <= next_state;
      wake_pend    <= ev_wake || (wake_pend && !in_boot && !in_hold);
      wake_int     <= ev_wake ? (ev_iwake && gie) : wake_int;
      pc_load_zero <= next_zero;
      wake_resume  <= wait_done && wake_pend;
      wake_vector  <= wait_done && wake_pend && wake_int;
    end
  end

  assign core_reset      = !(in_run || in_sleep);
  assign tif.start       = (in_boot && !bor_level) || ev_wake;
  assign tif.poweron     = in_boot;
  assign tif.delay_dis_n = powerup_delay_disable_n;
  assign tif.osc_mode    = osc_mode;

  rcs_startup_timer #(
    .POWERUP_TIMER_CYCLES (POWERUP_TIMER_CYCLES)
  ) u_timer (
    .clk   (clk),
    .rst_b (rst_b),
    .t     (tif.tmr)
  );

  // ****************************************
  // Reset cause flags
  // ****************************************
  logic ovf, unf, pinf, rif, porf, borf, to_st, pd_st;

  wire       power_control_status_wr = reg_wr && reg_addr == rcs_pkg::ADDR_POWER_CONTROL_STATUS;
  wire [7:0] wd      = reg_wdata;

  wire next_ovf  = ev_ovf ? 1'b1 : ev_bor ? 1'b0 :
                   power_control_status_wr ? wd[rcs_pkg::POWER_CONTROL_STATUS_OVF] : ovf;
  wire next_unf  = ev_unf ? 1'b1 : ev_bor ? 1'b0 :
                   power_control_status_wr ? wd[rcs_pkg::POWER_CONTROL_STATUS_UNF] : unf;
  wire next_pinf = ev_pin ? 1'b0 : ev_bor ? 1'b1 :
                   power_control_status_wr ? wd[rcs_pkg::POWER_CONTROL_STATUS_PIN] : pinf;
  wire next_rif  = ev_ri ? 1'b0 : ev_bor ? 1'b1 :
                   power_control_status_wr ? wd[rcs_pkg::POWER_CONTROL_STATUS_RI] : rif;
  wire next_porf = power_control_status_wr ? wd[rcs_pkg::POWER_CONTROL_STATUS_POR] : porf;
  wire next_borf = ev_bor ? 1'b0 :
                   power_control_status_wr ? wd[rcs_pkg::POWER_CONTROL_STATUS_BOR] : borf;
  wire next_to   = ev_bor ? 1'b1 : (ev_wdt || ev_wwake) ? 1'b0 :
                   (ev_iwake || pin_slp) ? 1'b1 : to_st;
  wire next_pd   = ev_bor ? 1'b1 :
                   (ev_wake || pin_slp || ev_sleep) ? 1'b0 : pd_st;

  // Hardware terms sit ahead of the write in each mux
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ovf   <= 1'b0;
      unf   <= 1'b0;
      pinf  <= 1'b1;
      rif   <= 1'b1;
      porf  <= 1'b0;
      borf  <= rcs_pkg::BOR_FLAG_RST;
      to_st <= 1'b1;
      pd_st <= 1'b1;
    end else begin
      ovf   <= next_ovf;
      unf   <= next_unf;
      pinf  <= next_pinf;
      rif   <= next_rif;
      porf  <= next_porf;
      borf  <= next_borf;
      to_st <= next_to;
      pd_st <= next_pd;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  logic [5:0] watchdog_control;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sw_brownout_enable <= rcs_pkg::SWEN_RST;
      watchdog_control             <= rcs_pkg::WATCHDOG_CONTROL_RST;
    end else begin
      if (reg_wr && reg_addr == rcs_pkg::ADDR_BROWNOUT_CONTROL)
        sw_brownout_enable <= wd[rcs_pkg::BROWNOUT_CONTROL_EN];
      if (reg_wr && reg_addr == rcs_pkg::ADDR_WATCHDOG_CONTROL)
        watchdog_control <= wd[5:0];
    end
  end

  assign wdt_period_sel = watchdog_control[5:1];
  assign wdt_sw_enable  = watchdog_control[0];

  // ****************************************
  // Read path
  // ****************************************
  wire [7:0] power_control_status_rd   = {ovf, unf, 2'h0, pinf, rif, porf, borf};
  wire [7:0] status_rd = {3'h0, to_st, pd_st, 3'h0};
  wire [7:0] brownout_control_rd = {sw_brownout_enable, 6'h00, bor_rdy};
  wire [7:0] watchdog_control_rd = {2'h0, watchdog_control};
  wire [7:0] rd_mux    =
    (reg_addr == rcs_pkg::ADDR_POWER_CONTROL_STATUS)   ? power_control_status_rd   :
    (reg_addr == rcs_pkg::ADDR_BROWNOUT_CONTROL) ? brownout_control_rd :
    (reg_addr == rcs_pkg::ADDR_STATUS) ? status_rd : watchdog_control_rd;

  always_ff @(posedge clk) begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_run_ovf;
    stack_overflow_evt && free_run && !wdt_timeout_evt;
  endsequence

  a_por_values: assert property (
    $rose(rst_b) |-> ovf == 1'b0 && unf == 1'b0 && pinf && rif &&
      !porf && to_st && pd_st && core_reset)
    else $error("power-on flag values wrong");

  a_ovf_sticky: assert property (
    s_run_ovf |=> ovf ##1 (ovf || $past(power_control_status_wr) || $past(ev_bor)))
    else $error("overflow flag not set or lost");

  a_unf_beats_wr: assert property (
    stack_underflow_evt && free_run && !wdt_timeout_evt && power_control_status_wr
    |=> unf)
    else $error("write beat underflow set");

  a_pin_clear: assert property (
    pin_fall && in_run && !bor_level |=> !pinf && core_reset)
    else $error("pin reset flag not cleared");

  a_ri_only: assert property (
    ev_ri && !power_control_status_wr |=> !rif && $stable(porf) && $stable(borf))
    else $error("reset instruction flags wrong");

  a_bor_values: assert property (
    ev_bor |=> !borf && !ovf && !unf && pinf && rif && to_st && pd_st)
    else $error("brown-out flag values wrong");

  a_wdt_reset: assert property (
    ev_wdt |=> !to_st && core_reset)
    else $error("watchdog reset status wrong");

  a_int_wake: assert property (
    ev_iwake |=> to_st && !pd_st)
    else $error("interrupt wake status wrong");

  a_pin_sleep: assert property (
    pin_slp |=> !pinf && to_st && !pd_st)
    else $error("pin reset in sleep status wrong");

  a_stack_noreset: assert property (
    (s_run_ovf and (!stack_fault_reset_en && !reset_instr_evt))
    |=> !core_reset)
    else $error("stack fault reset while disabled");

  a_stack_reset: assert property (
    (s_run_ovf and stack_fault_reset_en) |=> core_reset ##0 ovf)
    else $error("stack fault reset missing");

  a_hold_zero: assert property (
    hold_exit |=> pc_load_zero && !wake_resume)
    else $error("restart not at address zero");

  a_rsvd_zero: assert property (
    reg_rd && reg_addr == rcs_pkg::ADDR_POWER_CONTROL_STATUS |=> reg_rdata[5:4] == 2'h0)
    else $error("unimplemented bits read nonzero");

endmodule
`default_nettype wire

// ### rcs_pkg.sv
package rcs_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [1:0] ADDR_POWER_CONTROL_STATUS   = 2'h0;
  localparam logic [1:0] ADDR_BROWNOUT_CONTROL = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  localparam logic [1:0] ADDR_WATCHDOG_CONTROL = 2'h3;

  localparam int POWER_CONTROL_STATUS_OVF   = 7;
  localparam int POWER_CONTROL_STATUS_UNF   = 6;
  localparam int POWER_CONTROL_STATUS_PIN   = 3;
  localparam int POWER_CONTROL_STATUS_RI    = 2;
  localparam int POWER_CONTROL_STATUS_POR   = 1;
  localparam int POWER_CONTROL_STATUS_BOR   = 0;
  localparam int STATUS_TO  = 4;
  localparam int STATUS_PD  = 3;
  localparam int BROWNOUT_CONTROL_EN  = 7;
  localparam int BROWNOUT_CONTROL_RDY = 0;

  localparam logic       BOR_FLAG_RST = 1'h0;
  localparam logic       SWEN_RST     = 1'h1;
  localparam logic [5:0] WATCHDOG_CONTROL_RST   = 6'h16;
  localparam logic [2:0] SYNC_RST     = 3'h1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ      = 200;
  localparam int POWERUP_TIMER_MS      = 64;
  localparam int POWERUP_TIMER_CYCLES  = POWERUP_TIMER_MS * 1000 * CLK_MHZ;
  localparam int OST_PERIODS  = 1024;
  localparam int OST_CYCLES   = OST_PERIODS;
  localparam int SHORT_US     = 1;
  localparam int SHORT_CYCLES = SHORT_US * CLK_MHZ;
  localparam int CNT_W        = 24;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    OSC_XTAL   = 2'h0,
    OSC_EXTRC  = 2'h1,
    OSC_EXTCLK = 2'h2,
    OSC_INTOSC = 2'h3
  } rcs_osc_t;

  typedef enum logic [4:0] {
    ST_BOOT  = 5'h01,
    ST_WAIT  = 5'h02,
    ST_HOLD  = 5'h04,
    ST_RUN   = 5'h08,
    ST_SLEEP = 5'h10
  } rcs_state_t;

  typedef enum logic [2:0] {
    T_IDLE   = 3'h1,
    T_POWERUP_TIMER   = 3'h2,
    T_SECOND = 3'h4
  } rcs_tstate_t;

endpackage

// ### rcs_timer_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rcs_timer_if;
  logic             start;
  logic             poweron;
  logic             delay_dis_n;
  rcs_pkg::rcs_osc_t osc_mode;
  logic             done;
  modport ctrl (output start, poweron, delay_dis_n, osc_mode, input done);
  modport tmr  (input start, poweron, delay_dis_n, osc_mode, output done);
endinterface
`default_nettype wire

// ### rcs_startup_timer.sv
`timescale 1ns/1ps
`default_nettype none
module rcs_startup_timer #(
  parameter int POWERUP_TIMER_CYCLES = rcs_pkg::POWERUP_TIMER_CYCLES
) (
  input wire logic  clk,
  input wire logic  rst_b,
  rcs_timer_if.tmr  t
);
  localparam int CW      = rcs_pkg::CNT_W;
  localparam int A_SHORT = rcs_pkg::SHORT_CYCLES + 1;
  localparam int A_OST   = rcs_pkg::OST_CYCLES + 1;

  rcs_pkg::rcs_tstate_t phase;
  logic [CW-1:0]        cnt;
  logic [CW-1:0]        sec_q;
  logic                 done;

  // ****************************************
  // Delay selection
  // ****************************************
  wire use_powerup_timer = t.poweron && !t.delay_dis_n;
  wire is_xtal  = t.osc_mode == rcs_pkg::OSC_XTAL;
  wire is_int   = t.osc_mode == rcs_pkg::OSC_INTOSC;
  wire [CW-1:0] powerup_timer_len = use_powerup_timer ? CW'(POWERUP_TIMER_CYCLES) : '0;
  wire [CW-1:0] sec_len  = is_xtal ? CW'(rcs_pkg::OST_CYCLES) :
                           (is_int && !use_powerup_timer) ?
                           CW'(rcs_pkg::SHORT_CYCLES) : '0;
  wire          last     = cnt == CW'(1);
  wire          xtal_go  = t.start && !t.poweron && is_xtal &&
                           phase == rcs_pkg::T_IDLE;

  // Cycle count since a crystal wake started, for the check below
  logic [CW-1:0] xtal_age;
  logic          xtal_wait;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      xtal_age  <= '0;
      xtal_wait <= 1'b0;
    end else if (xtal_go) begin
      xtal_age  <= CW'(1);
      xtal_wait <= 1'b1;
    end else if (xtal_wait) begin
      xtal_age  <= xtal_age + CW'(1);
      xtal_wait <= !t.done;
    end
  end

  // ****************************************
  // Sequencer: power-up timer, then second stage
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      phase <= rcs_pkg::T_IDLE;
      cnt   <= '0;
      sec_q <= '0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      case (phase)
        rcs_pkg::T_IDLE: begin
          if (t.start) begin
            sec_q <= sec_len;
            if (powerup_timer_len != '0) begin
              phase <= rcs_pkg::T_POWERUP_TIMER;
              cnt   <= powerup_timer_len;
            end else if (sec_len != '0) begin
              phase <= rcs_pkg::T_SECOND;
              cnt   <= sec_len;
            end else begin
              done <= 1'b1;
            end
          end
        end
        rcs_pkg::T_POWERUP_TIMER: begin
          cnt <= cnt - CW'(1);
          if (last && sec_q != '0) begin
            phase <= rcs_pkg::T_SECOND;
            cnt   <= sec_q;
          end else if (last) begin
            phase <= rcs_pkg::T_IDLE;
            done  <= 1'b1;
          end
        end
        rcs_pkg::T_SECOND: begin
          cnt <= cnt - CW'(1);
          if (last) begin
            phase <= rcs_pkg::T_IDLE;
            done  <= 1'b1;
          end
        end
        default: phase <= rcs_pkg::T_IDLE;
      endcase
    end
  end

  assign t.done = done;

  a_short_wake: assert property (@(posedge clk) disable iff (!rst_b)
    t.start && !t.poweron && is_int && phase == rcs_pkg::T_IDLE
    |-> ##A_SHORT t.done)
    else $error("internal oscillator wake delay wrong");

  a_ost_wake: assert property (@(posedge clk) disable iff (!rst_b)
    xtal_wait |-> xtal_age <= CW'(A_OST) &&
      t.done == (xtal_age == CW'(A_OST)))
    else $error("crystal wake delay wrong");

  a_powerup_timer_first: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(phase == rcs_pkg::T_POWERUP_TIMER)
    |-> phase == rcs_pkg::T_SECOND || t.done)
    else $error("power-up timer stage ended wrongly");
endmodule
`default_nettype wire

// ### rcs_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Reset sources and core event pulses
// ****************
module rcs_src_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       fire,
  input  wire logic [2:0] kind,
  output logic            ext_reset_pin_b,
  output logic            bor_trip,
  output logic            brownout_ready,
  output logic [5:0]      core_evt
);
  logic [2:0] pin_cnt;
  logic [2:0] bor_cnt;
  logic [3:0] rdy_cnt;
  wire logic  hit_pin = fire && kind == 3'h6;
  wire logic  hit_bor = fire && kind == 3'h7;

  // Pin and detector stay active six cycles; detector rearms after eight
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_cnt  <= 3'h0;
      bor_cnt  <= 3'h0;
      rdy_cnt  <= 4'h0;
      core_evt <= 6'h00;
    end else begin
      core_evt <= (fire && kind < 3'h6) ? 6'h01 << kind : 6'h00;
      pin_cnt  <= hit_pin ? 3'h6 : pin_cnt - 3'(pin_cnt != 3'h0);
      bor_cnt  <= hit_bor ? 3'h6 : bor_cnt - 3'(bor_cnt != 3'h0);
      rdy_cnt  <= bor_trip ? 4'h0 : rdy_cnt + 4'(!rdy_cnt[3]);
    end
  end

  assign ext_reset_pin_b = pin_cnt == 3'h0;
  assign bor_trip        = bor_cnt != 3'h0;
  assign brownout_ready  = rdy_cnt[3];
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ****************
  // Signals
  // ****************
  localparam int     PW          = 20;
  logic              clk         = 1'b0;
  logic              rst_b       = 1'b0;
  logic [1:0]        reg_addr    = 2'h0;
  logic [7:0]        reg_wdata   = 8'h00;
  logic              reg_wr      = 1'b0;
  logic              reg_rd      = 1'b0;
  logic              gie         = 1'b0;
  logic              sfe         = 1'b0;
  logic              pdd_n       = 1'b0;
  logic              fire        = 1'b0;
  logic [2:0]        kind        = 3'h0;
  rcs_pkg::rcs_osc_t osc         = rcs_pkg::OSC_INTOSC;
  logic              slp         = 1'b0;
  int                mismatches  = 0;
  int                comparisons = 0;
  int                n_pcz       = 0;
  int                n_wres      = 0;
  int                n_wvec      = 0;
  logic [7:0]        reg_rdata, e_power_control_status, e_st, d;
  logic              pin_b, bor_trip, bor_rdy, core_reset, pcz, wres, wvec;
  logic              sbe, wen;
  logic [4:0]        wper;
  logic [5:0]        evt;

  initial forever #2.5 clk = ~clk;

  rcs_top #(.POWERUP_TIMER_CYCLES(PW)) dut (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_reset_pin_b(pin_b), .bor_trip(bor_trip), .brownout_ready(bor_rdy),
    .stack_overflow_evt(evt[0]), .stack_underflow_evt(evt[1]),
    .reset_instr_evt(evt[2]), .sleep_enter_evt(evt[3]),
    .wdt_timeout_evt(evt[4]), .int_wake_evt(evt[5]), .gie(gie),
    .stack_fault_reset_en(sfe), .powerup_delay_disable_n(pdd_n),
    .osc_mode(osc), .core_reset(core_reset), .pc_load_zero(pcz),
    .wake_resume(wres), .wake_vector(wvec), .sw_brownout_enable(sbe),
    .wdt_period_sel(wper), .wdt_sw_enable(wen));

  rcs_src_model src (
    .clk(clk), .rst_b(rst_b), .fire(fire), .kind(kind),
    .ext_reset_pin_b(pin_b), .bor_trip(bor_trip),
    .brownout_ready(bor_rdy), .core_evt(evt));

  always @(posedge clk) begin
    if (pcz === 1'b1) n_pcz++;
    if (wres === 1'b1) n_wres++;
    if (wvec === 1'b1) n_wvec++;
  end

  // ****************
  // Helpers
  // ****************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask

  task automatic go(input logic [2:0] k, input logic en, input logic g);
    @(posedge clk);
    fire <= 1'b1;
    kind <= k;
    sfe  <= en;
    gie  <= g;
    @(posedge clk);
    fire <= 1'b0;
  endtask

  task automatic wait_run(output int n);
    n = 0;
    while (core_reset !== 1'b0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) mismatches++;
  endtask

  function automatic logic [7:0] power_control_status_after(input logic [2:0] k,
                                            input logic [7:0] p);
    case (k)
      3'h0: return p | 8'h80;
      3'h1: return p | 8'h40;
      3'h2: return p & 8'hfb;
      3'h6: return p & 8'hf7;
      3'h7: return (p & 8'h02) | 8'h0c;
      default: return p;
    endcase
  endfunction

  function automatic logic [7:0] st_after(input logic [2:0] k,
                                          input logic [7:0] s, input logic z);
    case (k)
      3'h3: return s & 8'h10;
      3'h4: return z ? 8'h00 : (s & 8'h08);
      3'h5: return 8'h10;
      3'h6: return z ? 8'h10 : s;
      3'h7: return 8'h18;
      default: return s;
    endcase
  endfunction

  function automatic int pcz_after(input logic [2:0] k, input logic z,
                                   input logic en);
    if (k < 3'h2) return int'(en);
    if (k == 3'h4) return int'(!z);
    return int'(k == 3'h2 || k >= 3'h6);
  endfunction

  task automatic do_ev(input logic [2:0] k, input logic en, input logic g);
    int         p0, w0, v0, n;
    logic       z;
    p0 = n_pcz;
    w0 = n_wres;
    v0 = n_wvec;
    z = slp;
    e_power_control_status = power_control_status_after(k, e_power_control_status);
    e_st = st_after(k, e_st, z);
    slp = (k == 3'h3) ? 1'b1 : ((k >= 3'h4) ? 1'b0 : z);
    go(k, en, g);
    repeat (6) @(posedge clk);
    wait_run(n);
    rd(rcs_pkg::ADDR_POWER_CONTROL_STATUS, d);
    chk(d, e_power_control_status);
    rd(rcs_pkg::ADDR_STATUS, d);
    chk(d, e_st);
    chk(n_pcz - p0, pcz_after(k, z, en));
    chk(n_wres - w0, 32'(z && (k == 3'h4 || k == 3'h5)));
    chk(n_wvec - v0, 32'(z && k == 3'h5 && g));
    $display("test event %0d done", k);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ****************
  // Tests
  // ****************
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    give_verdict;
  end

  initial begin
    int         n;
    int         e;
    logic [2:0] seq [14];
    logic [7:0] v;
    seq = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h3, 3'h5,
            3'h3, 3'h5, 3'h3, 3'h4, 3'h3, 3'h6, 3'h7};
    void'($urandom(32'h6fe058d8));
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      rst_b <= 1'b0;
      osc   <= rcs_pkg::rcs_osc_t'(i[1:0]);
      pdd_n <= i[2];
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      wait_run(n);
      e = (i[2] ? 0 : PW) + (i[1:0] == 2'h0 ? 1024 : 0) + (i == 7 ? 200 : 0);
      chk(32'(n >= e && n <= e + 8), 1);
      rd(rcs_pkg::ADDR_POWER_CONTROL_STATUS, d);
      chk(d & 8'hfe, 8'h0c);
      rd(rcs_pkg::ADDR_STATUS, d);
      chk(d, 8'h18);
      wr(rcs_pkg::ADDR_POWER_CONTROL_STATUS, 8'hc3);
      $display("test power-on %0d done", i);
    end
    wr(rcs_pkg::ADDR_POWER_CONTROL_STATUS, 8'h0f);
    e_power_control_status = 8'h0f;
    e_st = 8'h18;
    for (int j = 0; j < 14; j++) begin
      if (j == 8) osc <= rcs_pkg::OSC_XTAL;
      do_ev(seq[j], (j == 1) || (j > 1 && $urandom_range(1) == 1),
            (j == 6) || (j != 8 && $urandom_range(1) == 1));
      if (j == 0) begin
        wr(rcs_pkg::ADDR_POWER_CONTROL_STATUS, 8'h0f);
        e_power_control_status = 8'h0f;
      end
    end
    for (int c = 1; c < 3; c++) begin
      @(posedge clk);
      fire <= 1'b1;
      kind <= 3'(c);
      @(posedge clk);
      fire      <= 1'b0;
      reg_wr    <= 1'b1;
      reg_addr  <= rcs_pkg::ADDR_POWER_CONTROL_STATUS;
      reg_wdata <= 8'h0f;
      @(posedge clk);
      reg_wr <= 1'b0;
      repeat (6) @(posedge clk);
      wait_run(n);
      rd(rcs_pkg::ADDR_POWER_CONTROL_STATUS, d);
      chk(d, (c == 2) ? 8'h0b : 8'h4f);
    end
    $display("test collision done");
    for (int j = 0; j < 20; j++) begin
      v = 8'($urandom);
      wr(rcs_pkg::ADDR_WATCHDOG_CONTROL, v);
      rd(rcs_pkg::ADDR_WATCHDOG_CONTROL, d);
      chk(d, v & 8'h3f);
      chk({wper, wen}, v[5:0]);
      wr(rcs_pkg::ADDR_BROWNOUT_CONTROL, v);
      rd(rcs_pkg::ADDR_BROWNOUT_CONTROL, d);
      chk(d, {v[7], 6'h00, 1'b1});
      chk(sbe, v[7]);
      wr(rcs_pkg::ADDR_STATUS, v);
      rd(rcs_pkg::ADDR_STATUS, d);
      chk(d, e_st);
      wr(rcs_pkg::ADDR_POWER_CONTROL_STATUS, v);
      rd(rcs_pkg::ADDR_POWER_CONTROL_STATUS, d);
      chk(d, v & 8'hcf);
      @(negedge clk);
      chk(reg_rdata, 8'h00);
    end
    $display("test registers done");
    give_verdict;
  end
endmodule
`default_nettype wire
